// ===== b2sp_pkg.sv
/*
  shared constants and types for the burst-of-two sram port: pin widths,
  lane layout, read latencies, synchroniser depth and host state codes.
  assumes both ends run on one 200 MHz clock and are joined by b2sp_if.
*/
// How it works
// - write data taken on both clock edges
// - controller drives load strobe low per transaction
// - every transaction moves exactly two beats
// - byte lane selects are active low
// - each select covers nine data bits
// - deselected lanes keep their stored contents
// - selects sampled with their own data beat
// - address taken on positive clock rise only
// - one shared address bus for both directions
// - two equal arrays, 20 or 19 address bits
// - address ignored when nothing is loaded
// - direction high reads, low writes
// - read beats launched by output clock pair
// - output clock may be phased for deskew; here c stays in phase with k
// - accesses start on positive input clock rise
// - free-running echo strobe follows output clock
// - pll bypass low selects short latency mode
package b2sp_pkg;

  // pin widths large enough for both variants; each one uses the low part
  localparam int ADDR_W      = 20;
  localparam int DATA_W      = 36;
  localparam int LANE_W      = 9;
  localparam int LANES       = 4;

  // variant shapes
  localparam int NARROW_DW   = 18;
  localparam int NARROW_AW   = 20;
  localparam int WIDE_DW     = 36;
  localparam int WIDE_AW     = 19;

  // transfer shape and timing
  localparam int BEATS       = 2;
  localparam int SYNC_STAGES = 2;
  localparam int LAT_PLL     = 3;   // output-clock edges, pll running
  localparam int LAT_BYPASS  = 2;   // output-clock edges, pll bypassed
  localparam int PIPE_DEPTH  = 5;
  localparam int FIFO_DEPTH  = 8;
  localparam int CLK_PERIOD_NS  = 5;
  localparam int BYPASS_FMAX_MHZ = 167;

  // host wait from issue to first returned beat, in clk cycles
  localparam logic [3:0] WAIT_PLL    = 4'(2 * SYNC_STAGES + 1 + LAT_PLL);
  localparam logic [3:0] WAIT_BYPASS = 4'(2 * SYNC_STAGES + 1 + LAT_BYPASS);

  typedef enum logic [2:0] {
    HOST_IDLE   = 3'b001,
    HOST_BEAT1  = 3'b010,
    HOST_RDWAIT = 3'b100
  } b2sp_host_state_type;

endpackage

// ===== b2sp_if.sv
/*
  pins between the memory controller end and the sram end.
  assumes both ends share clk_i; the complement clocks are implied by k and c.
*/
`timescale 1ns/1ps
interface b2sp_if;
  logic                         k;
  logic                         c;
  logic                         load_strobe_n;
  logic                         rw;
  logic [b2sp_pkg::ADDR_W-1:0]  addr;
  logic [b2sp_pkg::DATA_W-1:0]  d;
  logic [b2sp_pkg::LANES-1:0]   byte_lane_write_sel_n;
  logic                         pll_bypass_n;
  logic [b2sp_pkg::DATA_W-1:0]  q;
  logic                         echo_strobe;
  logic                         echo_strobe_n;

  modport host (
    output k, c, load_strobe_n, rw, addr, d, byte_lane_write_sel_n, pll_bypass_n,
    input  q, echo_strobe, echo_strobe_n
  );
  modport dev (
    input  k, c, load_strobe_n, rw, addr, d, byte_lane_write_sel_n, pll_bypass_n,
    output q, echo_strobe, echo_strobe_n
  );
endinterface

// ===== b2sp_fifo.sv
/*
  small fifo with valid/ready on both sides and a fill level.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module b2sp_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  // fill side
  input  wire logic                   in_valid_i,
  output logic                        in_ready_o,
  input  wire logic [WIDTH-1:0]       in_data_i,
  // drain side
  output logic                        out_valid_o,
  input  wire logic                   out_ready_i,
  output logic [WIDTH-1:0]            out_data_o,
  // status
  output logic [$clog2(DEPTH):0]      level_o
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW:0]      wr_ptr_ff;
  logic [PW:0]      rd_ptr_ff;
  logic             push;
  logic             pop;

  assign level_o     = wr_ptr_ff - rd_ptr_ff;
  assign in_ready_o  = (level_o != (PW+1)'(DEPTH));
  assign out_valid_o = (level_o != '0);
  assign out_data_o  = mem_ff[rd_ptr_ff[PW-1:0]];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr_ff <= '0;
    end else if (push) begin
      wr_ptr_ff <= wr_ptr_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_ptr_ff <= '0;
    end else if (pop) begin
      rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff[PW-1:0]] <= in_data_i;
    end
  end
endmodule

// ===== b2sp_dev.sv
/*
  sram end of the burst-of-two port: two beat arrays, lane-masked writes,
  read beats launched on output-clock edges with an echo strobe.
  assumes the controller drives the pins from clk_i; every pin passes two
  flip-flops here, all in lockstep, so clock and data stay aligned.
*/
`timescale 1ns/1ps
module b2sp_dev #(
  parameter bit WIDE = 1'b1
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // pins
  b2sp_if.dev       link,
  // strap: launch read data from k instead of c
  input  wire logic single_clock_i,
  // status
  output logic      bypass_active_o,
  output logic      access_o
);
  localparam int DW    = WIDE ? b2sp_pkg::WIDE_DW : b2sp_pkg::NARROW_DW;
  localparam int AW    = WIDE ? b2sp_pkg::WIDE_AW : b2sp_pkg::NARROW_AW;
  localparam int NL    = DW / b2sp_pkg::LANE_W;
  localparam int DEPTH = 1 << AW;
  localparam int LW    = b2sp_pkg::LANE_W;
  localparam int SS    = b2sp_pkg::SYNC_STAGES;
  localparam int PD    = b2sp_pkg::PIPE_DEPTH;
  localparam int IN_W  = 5 + b2sp_pkg::ADDR_W + b2sp_pkg::DATA_W + b2sp_pkg::LANES;

  // pin synchroniser, one wide vector so every pin sees the same delay
  logic [IN_W-1:0]                 pins;
  logic [IN_W-1:0]                 sync_ff [SS];
  logic                            s_pll_n;
  logic                            s_k;
  logic                            s_c;
  logic                            s_ld_n;
  logic                            s_rw;
  logic [b2sp_pkg::ADDR_W-1:0]     s_addr;
  logic [b2sp_pkg::DATA_W-1:0]     s_d;
  logic [b2sp_pkg::LANES-1:0]      s_sel_n;

  // edge detection and control
  logic                            k_prev_ff;
  logic                            launch_prev_ff;
  logic                            single_meta_ff;
  logic                            single_ff;
  logic                            bypass_ff;
  logic                            access_ff;
  logic                            wr_pend_ff;
  logic [AW-1:0]                   addr_ff;
  logic                            launch;
  logic                            k_rise;
  logic                            k_fall;
  logic                            launch_edge;
  logic                            load;
  logic                            load_wr;
  logic                            load_rd;
  logic [AW-1:0]                   a;

  // storage and read path
  logic [DW-1:0]                   arr0 [DEPTH];
  logic [DW-1:0]                   arr1 [DEPTH];
  logic [b2sp_pkg::DATA_W-1:0]     pipe_ff [PD];
  logic [b2sp_pkg::DATA_W-1:0]     rd0;
  logic [b2sp_pkg::DATA_W-1:0]     rd1;
  logic [b2sp_pkg::DATA_W-1:0]     q_ff;
  logic                            echo_ff;
  logic                            echo_n_ff;
  int                              ins;

  assign pins = {link.pll_bypass_n, link.k, link.c, link.load_strobe_n, link.rw,
                 link.addr, link.d, link.byte_lane_write_sel_n};

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < SS; i++) begin
        sync_ff[i] <= '0;
      end
    end else begin
      sync_ff[0] <= pins;
      for (int i = 1; i < SS; i++) begin
        sync_ff[i] <= sync_ff[i-1];
      end
    end
  end

  assign {s_pll_n, s_k, s_c, s_ld_n, s_rw, s_addr, s_d, s_sel_n} = sync_ff[SS-1];

  // strap and mode are caught by clocked logic, never by the reset itself
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      single_meta_ff <= 1'b0;
      single_ff      <= 1'b0;
      bypass_ff      <= 1'b0;
    end else begin
      single_meta_ff <= single_clock_i;
      single_ff      <= single_meta_ff;
      bypass_ff <= ~s_pll_n;
    end
  end

  assign launch      = single_ff ? s_k : s_c;
  assign k_rise      = s_k & ~k_prev_ff;
  assign k_fall      = ~s_k & k_prev_ff;
  assign launch_edge = launch ^ launch_prev_ff;
  assign load        = k_rise & ~s_ld_n;
  assign load_wr     = load & ~s_rw;
  assign load_rd     = load & s_rw;
  // one address bus for reads and writes, used only on a loaded rise
  assign a           = s_addr[AW-1:0];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      k_prev_ff      <= 1'b0;
      launch_prev_ff <= 1'b0;
    end else begin
      k_prev_ff      <= s_k;
      launch_prev_ff <= launch;
    end
  end

  // address held only from a loaded rise; other cycles leave it alone
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      addr_ff    <= '0;
      wr_pend_ff <= 1'b0;
    end else begin
      if (load) begin
        addr_ff <= a;
      end
      if (load_wr) begin
        wr_pend_ff <= 1'b1;
      end else if (k_fall) begin
        wr_pend_ff <= 1'b0;
      end
    end
  end

  // first beat on the k rise into array 0, second on the k-complement rise
  // into array 1; each lane is written only if its own beat select is low
  always_ff @(posedge clk_i) begin
    for (int l = 0; l < NL; l++) begin
      if (load_wr && !s_sel_n[l]) begin
        arr0[a][l*LW +: LW] <= s_d[l*LW +: LW];
      end
      if (k_fall && wr_pend_ff && !s_sel_n[l]) begin
        arr1[addr_ff][l*LW +: LW] <= s_d[l*LW +: LW];
      end
    end
  end

  always_comb begin
    rd0 = '0;
    rd1 = '0;
    rd0[DW-1:0] = arr0[a];
    rd1[DW-1:0] = arr1[a];
  end

  // insertion slot sets the latency in launch edges; a launch edge in the
  // same cycle has already moved everything one place down
  always_comb begin
    ins = bypass_ff ? b2sp_pkg::LAT_BYPASS : b2sp_pkg::LAT_PLL;
    if (launch_edge) begin
      ins = ins - 1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < PD; i++) begin
        pipe_ff[i] <= '0;
      end
    end else begin
      if (launch_edge) begin
        for (int i = 0; i < PD - 1; i++) begin
          pipe_ff[i] <= pipe_ff[i+1];
        end
        pipe_ff[PD-1] <= '0;
      end
      if (load_rd) begin
        pipe_ff[ins]   <= rd0;
        pipe_ff[ins+1] <= rd1;
      end
    end
  end

  // one beat per launch edge, rise and fall alike
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q_ff <= '0;
    end else if (launch_edge) begin
      q_ff <= pipe_ff[0];
    end
  end

  // echo runs whether or not data moves, so the far end can always track it
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      echo_ff   <= 1'b0;
      echo_n_ff <= 1'b1;
    end else begin
      echo_ff   <= launch;
      echo_n_ff <= ~launch;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      access_ff <= 1'b0;
    end else begin
      access_ff <= load;
    end
  end

  assign link.q             = q_ff;
  assign link.echo_strobe   = echo_ff;
  assign link.echo_strobe_n = echo_n_ff;
  assign bypass_active_o    = bypass_ff;
  assign access_o           = access_ff;
endmodule

// ===== b2sp_host.sv
/*
  controller end of the burst-of-two port: issues at most one transaction per
  input-clock period, none while a read awaits its beats, drives k and c as clk_i divided by two, and collects
  read beats into a fifo. assumes the far end is b2sp_dev on the same clk_i.
*/
`timescale 1ns/1ps
module b2sp_host #(
  parameter bit WIDE = 1'b1
) (
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          reset_i,
  // pins
  b2sp_if.host                               link,
  // command
  input  wire logic                          cmd_valid_i,
  output logic                               cmd_ready_o,
  input  wire logic                          cmd_read_i,
  input  wire logic [b2sp_pkg::ADDR_W-1:0]   cmd_addr_i,
  input  wire logic [b2sp_pkg::DATA_W-1:0]   wr_data0_i,
  input  wire logic [b2sp_pkg::DATA_W-1:0]   wr_data1_i,
  input  wire logic [b2sp_pkg::LANES-1:0]    wr_sel0_n_i,
  input  wire logic [b2sp_pkg::LANES-1:0]    wr_sel1_n_i,
  input  wire logic                          pll_bypass_n_i,
  // read beats
  output logic                               rd_valid_o,
  input  wire logic                          rd_ready_i,
  output logic [b2sp_pkg::DATA_W-1:0]        rd_data_o
);
  localparam int LN = WIDE ? b2sp_pkg::LANES : b2sp_pkg::LANES / 2;
  localparam logic [b2sp_pkg::LANES-1:0] MASK_N = ~((b2sp_pkg::LANES)'((1 << LN) - 1));
  localparam int FLW = $clog2(b2sp_pkg::FIFO_DEPTH) + 1;
  localparam logic [FLW-1:0] ROOM = FLW'(b2sp_pkg::FIFO_DEPTH - b2sp_pkg::BEATS);

  b2sp_pkg::b2sp_host_state_type state_ff;
  b2sp_pkg::b2sp_host_state_type nxt_state;
  logic                          k_ff;
  logic                          c_ff;
  logic                          ld_n_ff;
  logic                          rw_ff;
  logic [b2sp_pkg::ADDR_W-1:0]   addr_ff;
  logic [b2sp_pkg::DATA_W-1:0]   d_ff;
  logic [b2sp_pkg::DATA_W-1:0]   d1_ff;
  logic [b2sp_pkg::LANES-1:0]    sel_n_ff;
  logic [b2sp_pkg::LANES-1:0]    sel1_n_ff;
  logic                          pll_n_ff;
  logic                          ready_ff;
  logic [3:0]                    wait_ff;
  logic [1:0]                    beats_ff;
  logic [b2sp_pkg::DATA_W:0]     rx_sync_ff [b2sp_pkg::SYNC_STAGES];
  logic                          echo_prev_ff;
  logic                          echo_s;
  logic [b2sp_pkg::DATA_W-1:0]   q_s;
  logic                          accept;
  logic                          capture;
  logic                          fifo_in_ready;
  logic [FLW-1:0]                fifo_level;

  assign accept  = cmd_valid_i & ready_ff;
  assign {echo_s, q_s} = rx_sync_ff[b2sp_pkg::SYNC_STAGES-1];
  assign capture = (beats_ff != 2'h0) & (wait_ff == 4'h0) & (echo_s ^ echo_prev_ff) &
                   fifo_in_ready;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      b2sp_pkg::HOST_IDLE:   nxt_state = accept ? b2sp_pkg::HOST_BEAT1 : b2sp_pkg::HOST_IDLE;
      b2sp_pkg::HOST_BEAT1:  nxt_state = rw_ff ? b2sp_pkg::HOST_RDWAIT : b2sp_pkg::HOST_IDLE;
      b2sp_pkg::HOST_RDWAIT: begin
        if (capture && beats_ff == 2'h1) begin
          nxt_state = b2sp_pkg::HOST_IDLE;
        end
      end
      default:               nxt_state = b2sp_pkg::HOST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_ff <= b2sp_pkg::HOST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // k and c run free; c is kept in phase with k, so no deskew offset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      k_ff     <= 1'b0;
      c_ff     <= 1'b0;
      pll_n_ff <= 1'b1;
    end else begin
      k_ff     <= ~k_ff;
      c_ff     <= ~c_ff;
      pll_n_ff <= pll_bypass_n_i;
    end
  end

  // ready only in the half period before a k rise, with room for two beats
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= (nxt_state == b2sp_pkg::HOST_IDLE) & k_ff & (fifo_level <= ROOM);
    end
  end

  // beat 0 rides with the k rise, beat 1 with the k fall
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ld_n_ff   <= 1'b1;
      rw_ff     <= 1'b1;
      addr_ff   <= '0;
      d_ff      <= '0;
      d1_ff     <= '0;
      sel_n_ff  <= '1;
      sel1_n_ff <= '1;
    end else if (accept) begin
      ld_n_ff   <= 1'b0;
      rw_ff     <= cmd_read_i;
      addr_ff   <= cmd_addr_i;
      d_ff      <= wr_data0_i;
      d1_ff     <= wr_data1_i;
      sel_n_ff  <= wr_sel0_n_i | MASK_N;
      sel1_n_ff <= wr_sel1_n_i | MASK_N;
    end else if (state_ff == b2sp_pkg::HOST_BEAT1) begin
      ld_n_ff   <= 1'b1;
      d_ff      <= d1_ff;
      sel_n_ff  <= sel1_n_ff;
    end else begin
      ld_n_ff   <= 1'b1;
      sel_n_ff  <= '1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wait_ff  <= '0;
      beats_ff <= '0;
    end else if (accept) begin
      wait_ff  <= pll_n_ff ? b2sp_pkg::WAIT_PLL : b2sp_pkg::WAIT_BYPASS;
      beats_ff <= cmd_read_i ? 2'(b2sp_pkg::BEATS) : 2'h0;
    end else begin
      if (wait_ff != 4'h0) begin
        wait_ff <= wait_ff - 4'h1;
      end
      if (capture) begin
        beats_ff <= beats_ff - 2'h1;
      end
    end
  end

  // returned beats and echo pass two flops before anything looks at them
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < b2sp_pkg::SYNC_STAGES; i++) begin
        rx_sync_ff[i] <= '0;
      end
      echo_prev_ff <= 1'b0;
    end else begin
      rx_sync_ff[0] <= {link.echo_strobe, link.q};
      for (int i = 1; i < b2sp_pkg::SYNC_STAGES; i++) begin
        rx_sync_ff[i] <= rx_sync_ff[i-1];
      end
      echo_prev_ff <= echo_s;
    end
  end

  b2sp_fifo #(
    .WIDTH (b2sp_pkg::DATA_W),
    .DEPTH (b2sp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (capture),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (q_s),
    .out_valid_o (rd_valid_o),
    .out_ready_i (rd_ready_i),
    .out_data_o  (rd_data_o),
    .level_o     (fifo_level)
  );

  assign link.k                     = k_ff;
  assign link.c                     = c_ff;
  assign link.load_strobe_n         = ld_n_ff;
  assign link.rw                    = rw_ff;
  assign link.addr                  = addr_ff;
  assign link.d                     = d_ff;
  assign link.byte_lane_write_sel_n = sel_n_ff;
  assign link.pll_bypass_n          = pll_n_ff;
  assign cmd_ready_o                = ready_ff;
endmodule

// ===== b2sp_sva.sv
/*
  concurrent checks on the pins between the controller end and the sram end.
  assumes the testbench hands in the interface signals and the shared clock.
*/
`timescale 1ns/1ps
module b2sp_sva (
  // clock and reset
  input wire logic                             clk_i,
  input wire logic                             reset_i,
  // pins
  input wire logic                             k,
  input wire logic                             c,
  input wire logic                             load_strobe_n,
  input wire logic                             rw,
  input wire logic [b2sp_pkg::ADDR_W-1:0]      addr,
  input wire logic [b2sp_pkg::DATA_W-1:0]      d,
  input wire logic [b2sp_pkg::LANES-1:0]       byte_lane_write_sel_n,
  input wire logic                             pll_bypass_n,
  input wire logic [b2sp_pkg::DATA_W-1:0]      q,
  input wire logic                             echo_strobe,
  input wire logic                             echo_strobe_n
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // cycles since reset release, saturating; echo needs the synchroniser to fill
  logic [3:0] run_cnt_ff;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      run_cnt_ff <= 4'h0;
    end else if (run_cnt_ff != 4'hf) begin
      run_cnt_ff <= run_cnt_ff + 4'h1;
    end
  end

  property p_k_toggles; (run_cnt_ff != 4'h0) |-> (k != $past(k)); endproperty
  a_k_toggles: assert property (p_k_toggles) else $error("k missed a toggle");
  property p_c_with_k; c == k; endproperty
  a_c_with_k: assert property (p_c_with_k) else $error("c differs from k");
  property p_load_k_high; !load_strobe_n |-> k; endproperty
  a_load_k_high: assert property (p_load_k_high) else $error("load outside k high");
  property p_load_single; !load_strobe_n |=> load_strobe_n; endproperty
  a_load_single: assert property (p_load_single) else $error("load held two cycles");
  // a back-to-back write may load again right after the second beat
  property p_write_two_beats;
    (!load_strobe_n && !rw) |=> (!k && load_strobe_n) ##1
      (byte_lane_write_sel_n == 4'hf || !load_strobe_n);
  endproperty
  a_write_two_beats: assert property (p_write_two_beats) else $error("write shape");
  property p_idle_sel; (k && load_strobe_n) |-> (byte_lane_write_sel_n == 4'hf); endproperty
  a_idle_sel: assert property (p_idle_sel) else $error("idle lane select");
  property p_read_spacing; (!load_strobe_n && rw) |=> load_strobe_n [*8]; endproperty
  a_read_spacing: assert property (p_read_spacing) else $error("load during read");
  property p_echo_pair; echo_strobe_n == !echo_strobe; endproperty
  a_echo_pair: assert property (p_echo_pair) else $error("echo pair mismatch");
  property p_echo_runs; (run_cnt_ff == 4'hf) |-> (echo_strobe != $past(echo_strobe)); endproperty
  a_echo_runs: assert property (p_echo_runs) else $error("echo strobe stopped");

  c_write: cover property (!load_strobe_n && !rw);
  c_read: cover property (!load_strobe_n && rw);
  c_partial: cover property (!k && byte_lane_write_sel_n != 4'hf && byte_lane_write_sel_n != 4'h0);
endmodule

// ===== burst2_sram_port_test.sv
/*
  self-checking bench: controller end and sram end joined by b2sp_if.
  assumes the wide variant; a reference model keyed by 19 address bits.
*/
`timescale 1ns/1ps
module burst2_sram_port_test;
  logic        clk_i;
  logic        reset_i;
  logic        cmd_valid_i;
  logic        cmd_ready_o;
  logic        cmd_read_i;
  logic [19:0] cmd_addr_i;
  logic [35:0] wr_data0_i;
  logic [35:0] wr_data1_i;
  logic [3:0]  wr_sel0_n_i;
  logic [3:0]  wr_sel1_n_i;
  logic        pll_bypass_n_i;
  logic        rd_valid_o;
  logic        rd_ready_i;
  logic [35:0] rd_data_o;
  logic        single_clock_i;
  logic        bypass_active_o;
  logic        access_o;
  logic        stall;
  int          error_cnt;
  int          checks;
  int          issued;
  int          accesses;
  logic [35:0] mem0 [int];
  logic [35:0] mem1 [int];
  logic [35:0] exp_q [$];
  logic [19:0] adr [4];

  b2sp_if b2sp_if_i ();
  b2sp_host #(.WIDE(1'b1)) b2sp_host_i (.clk_i(clk_i), .reset_i(reset_i), .link(b2sp_if_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_read_i(cmd_read_i),
    .cmd_addr_i(cmd_addr_i), .wr_data0_i(wr_data0_i), .wr_data1_i(wr_data1_i),
    .wr_sel0_n_i(wr_sel0_n_i), .wr_sel1_n_i(wr_sel1_n_i), .pll_bypass_n_i(pll_bypass_n_i),
    .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o));
  b2sp_dev #(.WIDE(1'b1)) b2sp_dev_i (.clk_i(clk_i), .reset_i(reset_i), .link(b2sp_if_i),
    .single_clock_i(single_clock_i), .bypass_active_o(bypass_active_o), .access_o(access_o));
  b2sp_sva b2sp_sva_i (.clk_i(clk_i), .reset_i(reset_i), .k(b2sp_if_i.k), .c(b2sp_if_i.c),
    .load_strobe_n(b2sp_if_i.load_strobe_n), .rw(b2sp_if_i.rw), .addr(b2sp_if_i.addr),
    .d(b2sp_if_i.d), .byte_lane_write_sel_n(b2sp_if_i.byte_lane_write_sel_n),
    .pll_bypass_n(b2sp_if_i.pll_bypass_n), .q(b2sp_if_i.q),
    .echo_strobe(b2sp_if_i.echo_strobe), .echo_strobe_n(b2sp_if_i.echo_strobe_n));

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] nw,
                                        input logic [3:0] sel_n);
    logic [35:0] r;
    r = old;
    for (int l = 0; l < 4; l++) begin
      if (!sel_n[l]) r[9*l +: 9] = nw[9*l +: 9];
    end
    return r;
  endfunction

  function automatic logic [35:0] rnd36();
    return 36'({$urandom(), $urandom()});
  endfunction

  // one command; the model is updated at the accepting edge
  task automatic issue(input logic rd, input logic [19:0] a, input logic [35:0] d0,
                       input logic [35:0] d1, input logic [3:0] s0, input logic [3:0] s1);
    int key;
    int n;
    key = int'(a[18:0]);
    n = 0;
    @(negedge clk_i);
    cmd_valid_i = 1'b1;
    cmd_read_i = rd;
    cmd_addr_i = a;
    wr_data0_i = d0;
    wr_data1_i = d1;
    wr_sel0_n_i = s0;
    wr_sel1_n_i = s1;
    while (cmd_ready_o !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    if (cmd_ready_o !== 1'b1) begin
      error_cnt++;
      finish_test();
    end
    @(posedge clk_i);
    issued++;
    if (rd) begin
      exp_q.push_back(mem0[key]);
      exp_q.push_back(mem1[key]);
    end else begin
      mem0[key] = merge(mem0.exists(key) ? mem0[key] : 36'h0, d0, s0);
      mem1[key] = merge(mem1.exists(key) ? mem1[key] : 36'h0, d1, s1);
    end
  endtask

  task automatic idle_drain();
    int n;
    n = 0;
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    while ((exp_q.size() != 0 || rd_valid_o !== 1'b0) && n < 500) begin
      @(negedge clk_i);
      n++;
    end
    if (exp_q.size() != 0 || rd_valid_o !== 1'b0) begin
      error_cnt++;
      finish_test();
    end
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // consumer stalls at random, or fully while the fifo is being filled
  always @(negedge clk_i) rd_ready_i <= stall ? 1'b0 : ($urandom_range(3) != 0);

  always @(posedge clk_i) begin
    if (!reset_i && access_o === 1'b1) accesses++;
    if (!reset_i && rd_valid_o === 1'b1 && rd_ready_i === 1'b1) begin
      check(rd_data_o, exp_q.size() > 0 ? exp_q.pop_front() : {36{1'bx}});
    end
  end

  initial begin
    int n;
    void'($urandom(32'h48c8));
    {error_cnt, checks, issued, accesses} = '0;
    {stall, cmd_valid_i, cmd_read_i, single_clock_i} = '0;
    reset_i = 1'b1;
    cmd_addr_i = '0;
    wr_data0_i = '0;
    wr_data1_i = '0;
    wr_sel0_n_i = '1;
    wr_sel1_n_i = '1;
    pll_bypass_n_i = 1'b1;
    // every pairing of strap and latency mode, each after its own reset
    for (int m = 0; m < 4; m++) begin
      @(negedge clk_i);
      reset_i = 1'b1;
      single_clock_i = m[1];
      pll_bypass_n_i = !m[0];
      repeat (8) @(negedge clk_i);
      reset_i = 1'b0;
      repeat (10) @(negedge clk_i);
      check(36'(bypass_active_o), 36'(!pll_bypass_n_i));
      for (int i = 0; i < 4; i++) begin
        adr[i] = (i == 0) ? 20'h00000 : (i == 1) ? 20'h7ffff : 20'($urandom());
        issue(1'b0, adr[i], rnd36(), rnd36(), 4'h0, 4'h0);
      end
      // bit 19 is not decoded; a different lane on each beat
      for (int l = 0; l < 4; l++) begin
        issue(1'b0, adr[l] ^ 20'h80000, rnd36(), rnd36(), ~(4'h1 << l), ~(4'h8 >> l));
      end
      for (int i = 0; i < 4; i++) issue(1'b1, adr[i], '0, '0, '1, '1);
      idle_drain();
      // fill the fifo with the consumer stalled; further commands must be refused
      stall = 1'b1;
      for (int i = 0; i < 4; i++) issue(1'b1, adr[3 - i], '0, '0, '1, '1);
      @(negedge clk_i);
      cmd_valid_i = 1'b0;
      n = 0;
      repeat (30) begin
        @(negedge clk_i);
        n += int'(cmd_ready_o === 1'b1);
      end
      check(36'(n), 36'h0);
      stall = 1'b0;
      idle_drain();
    end
    check(36'(accesses), 36'(issued));
    finish_test();
  end
endmodule
